// >>> design/mcu8_call_io_timer_decode.sv
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RULE1: Call pushes PC and upper status bits, bumps pointer, loads operand and bank flag.
// RULE2: Plain return pops PC only; status unchanged; interrupt disable kept.
// RULE3: Return-restore pops PC and status bits; re-enables interrupts afterwards.
// RULE4: Port input copies port 1 or 2 pins into accumulator; one byte, two cycles.
// RULE5: Port output latches accumulator onto port 1 or 2; one byte, two cycles.
// RULE6: Port AND/OR immediate combines port with second byte and drives result back.
// RULE7: Bus input reads data bus into accumulator; one byte, two cycles.
// RULE8: Bus output latches accumulator on data bus; one byte, two cycles.
// RULE9: Bus AND/OR immediate combines bus latch with immediate and outputs it.
// RULE10: Expander input loads 4-bit port into low accumulator, clears upper nibble.
// RULE11: Expander output sends low accumulator nibble to port 4-7; accumulator unchanged.
// RULE12: Expander AND/OR combines port nibble with low accumulator and writes back.
// RULE13: Bank select opcodes clear or set the register bank bit.
// RULE14: Clock-out enable makes test pin zero drive internal clock thereafter.
// RULE15: Timer read copies counter into accumulator.
// RULE16: Timer load copies accumulator into counter.
// RULE17: Start timer counts internal clock, one count per 80 us.
// RULE18: Start counter counts test pin one high-to-low edges, minimum 7.5 us apart.
// RULE19: Stop halts counting in either mode.
// RULE20: Counter irq enable sets overflow interrupt enable flag.
// RULE21: Counter irq disable clears enable and pending latch, not the overflow flag.
// RULE22: Add, add-carry and decimal adjust set carry and aux carry from overflows.
// RULE23: Stack uses low three pointer bits, wrapping within eight entries.
module mcu8_call_io_timer_decode
   import mcu8_decode_pkg::*;
#(
   parameter int TIMER_CYC = TIMER_PERIOD_CYC
) (
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic OP_VALID_I,
   input wire logic [7:0] OP_BYTE0_I,
   input wire logic [7:0] OP_BYTE1_I,
   input wire logic [7:0] ACC_I,
   input wire logic [11:0] PC_NEXT_I,
   input wire logic CARRY_I,
   input wire logic [7:0] OPERAND_I,
   input wire logic [7:0] P1_I,
   input wire logic [7:0] P2_I,
   input wire logic [7:0] BUS_I,
   input wire logic [3:0] EXP_I,
   input wire logic TEST_PIN_ONE_I,
   input wire logic MEMORY_BANK_FLAG_I,
   output logic OP_DONE_O,
   output logic ACC_WE_O,
   output logic [7:0] ACC_O,
   output logic PC_WE_O,
   output logic [11:0] PC_O,
   output logic [7:0] PROGRAM_STATUS_WORD_O,
   output logic [2:0] STACK_POINTER_O,
   output logic [7:0] P1_O,
   output logic [7:0] P2_O,
   output logic [7:0] BUS_O,
   output logic BUS_OE_O,
   output logic [1:0] EXP_PORT_O,
   output logic [3:0] EXP_DATA_O,
   output logic EXP_WE_O,
   output logic BANK_SELECT_BIT_O,
   output logic CLOCK_OUT_ENABLE_O,
   output logic TEST_PIN_ZERO_O,
   output logic [7:0] TIMER_O,
   output logic TIMER_OVERFLOW_FLAG_O,
   output logic COUNTER_IRQ_ENABLE_FLAG_O,
   output logic COUNTER_IRQ_PENDING_O,
   output logic IRQ_BLOCKED_O
);

   typedef enum {IDLE, EXEC2} phase_e;
   typedef enum {STOPPED, TIMER_MODE, EVENT_MODE} cnt_mode_e;

   function automatic alu_result_s add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
      logic [4:0] lo;
      logic [8:0] full;
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      add8 = '{carry: full[8], aux_carry: lo[4], value: full[7:0]};
   endfunction

   phase_e phase;
   cnt_mode_e cnt_mode;
   stack_entry_s stack [STACK_DEPTH];
   logic [2:0] sp;
   logic [3:0] psw_hi;
   logic [7:0] op;
   logic [7:0] imm;
   alu_result_s alu_r;
   logic alu_flags;
   logic t1_meta, t1_s, t1_prev;
   logic [15:0] prescale;
   logic clk_div;
   logic irq_blocked_pending;

   wire logic is_call = (op[4:0] == OP_CALL_LOW[4:0]) && (OP_CALL_MASK != 5'h00);
   wire logic [1:0] pp = op[1:0];
   wire logic port12 = (pp == 2'h1) || (pp == 2'h2);
   wire stack_entry_s top = stack[sp - 3'h1];

   // Opcode capture and two-cycle sequencing
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         phase <= IDLE;
         op <= 8'h00;
         imm <= 8'h00;
      end else begin
         if (phase == IDLE && OP_VALID_I) begin
            op <= OP_BYTE0_I;
            imm <= OP_BYTE1_I;
            phase <= EXEC2;
         end else begin
            phase <= IDLE;
         end
      end
   end

   wire logic exec = (phase == EXEC2);
   assign OP_DONE_O = exec;

   // Accumulator and PC effects, combinational from the captured opcode
   always_comb begin
      alu_r = '0;
      alu_flags = 1'b0;
      ACC_WE_O = 1'b0;
      ACC_O = 8'h00;
      PC_WE_O = 1'b0;
      PC_O = 12'h000;
      if (exec) begin
         if (is_call) begin
            PC_WE_O = 1'b1; // see RULE1
            PC_O = {MEMORY_BANK_FLAG_I, op[7:5], imm};
         end else if (op == OP_RET || op == OP_RETURN_RESTORE_STATUS) begin
            PC_WE_O = 1'b1; // see RULE2
            PC_O = top.pc;
         end else if ((op == (OP_IN_BASE | {6'h00, pp})) && port12) begin
            ACC_WE_O = 1'b1; // see RULE4
            ACC_O = (pp == 2'h1) ? P1_I : P2_I;
         end else if (op == OP_IN_BASE) begin
            ACC_WE_O = 1'b1; // see RULE7
            ACC_O = BUS_I;
         end else if (op == (OP_EXIN_BASE | {6'h00, pp})) begin
            ACC_WE_O = 1'b1; // see RULE10
            ACC_O = {4'h0, EXP_I};
         end else if (op == OP_MOV_A_T) begin
            ACC_WE_O = 1'b1; // see RULE15
            ACC_O = TIMER_O;
         end else if ((op & 8'hF8) == (OP_ADD_BASE | 8'h08) || (op & 8'hFE) == OP_ADD_BASE) begin
            // Register and indirect forms only; the rest of this column is timer and rotate
            alu_r = add8(ACC_I, OPERAND_I, 1'b0); // see RULE22
            alu_flags = 1'b1;
         end else if ((op & 8'hF8) == (OP_ADDC_BASE | 8'h08) || (op & 8'hFE) == OP_ADDC_BASE) begin
            alu_r = add8(ACC_I, OPERAND_I, CARRY_I); // see RULE22
            alu_flags = 1'b1;
         end else if (op == OP_ADD_IMM || op == OP_ADDC_IMM) begin
            alu_r = add8(ACC_I, imm, (op == OP_ADDC_IMM) & CARRY_I); // see RULE22
            alu_flags = 1'b1;
         end else if (op == OP_DA) begin
            alu_r = daa(ACC_I, psw_hi[3], psw_hi[2]); // see RULE22
            alu_flags = 1'b1;
         end
         if (alu_flags) begin
            ACC_WE_O = 1'b1;
            ACC_O = alu_r.value;
         end
      end
   end

   // Decimal adjust produces its own carries
   function automatic alu_result_s daa(input logic [7:0] a, input logic c, input logic ac);
      logic [8:0] t;
      logic h;
      h = (a[3:0] > 4'h9) || ac;
      t = {1'b0, a} + (h ? 9'h006 : 9'h000);
      if (t[7:4] > 4'h9 || c || t[8])
         t = t + 9'h060;
      daa = '{carry: t[8] | c, aux_carry: h, value: t[7:0]};
   endfunction

   // Carry and aux carry updates plus bank bit
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         psw_hi <= 4'h0;
      end else if (exec) begin
         if (op == OP_RETURN_RESTORE_STATUS) begin
            psw_hi <= top.psw_hi; // see RULE3
         end else if (op == OP_SEL_RB0) begin
            psw_hi[0] <= 1'b0; // see RULE13
         end else if (op == OP_SELECT_REG_BANK_ONE) begin
            psw_hi[0] <= 1'b1; // see RULE13
         end else if (alu_flags) begin
            psw_hi[3] <= alu_r.carry; // see RULE22
            psw_hi[2] <= alu_r.aux_carry;
         end
      end
   end

   assign PROGRAM_STATUS_WORD_O = {psw_hi, 1'b1, sp};
   assign BANK_SELECT_BIT_O = psw_hi[0];
   assign STACK_POINTER_O = sp;

   // Stack push and pop within eight entries
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sp <= 3'h0;
      end else if (exec) begin
         if (is_call) begin
            stack[sp] <= '{pc: PC_NEXT_I, psw_hi: psw_hi}; // see RULE1
            sp <= sp + 3'h1; // see RULE23
         end else if (op == OP_RET || op == OP_RETURN_RESTORE_STATUS) begin
            sp <= sp - 3'h1; // see RULE23
         end
      end
   end

   // Interrupt acceptance: RETURN_RESTORE_STATUS re-enables after its execution
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         irq_blocked_pending <= 1'b0;
      end else if (exec && op == OP_RETURN_RESTORE_STATUS) begin
         irq_blocked_pending <= 1'b0; // see RULE3
      end else if (exec && is_call) begin
         irq_blocked_pending <= 1'b1;
      end
   end
   assign IRQ_BLOCKED_O = irq_blocked_pending; // see RULE2

   // Port and bus latches
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         P1_O <= RESET_BYTE;
         P2_O <= RESET_BYTE;
         BUS_O <= 8'h00;
         BUS_OE_O <= 1'b0;
      end else if (exec) begin
         if (op == (OP_PORT_OUTPUT_LATCH_BASE | {6'h00, pp}) && port12) begin
            if (pp == 2'h1) P1_O <= ACC_I; // see RULE5
            else P2_O <= ACC_I;
         end else if (op == (OP_ANL_BASE | {6'h00, pp}) && port12) begin
            if (pp == 2'h1) P1_O <= P1_O & imm; // see RULE6
            else P2_O <= P2_O & imm;
         end else if (op == (OP_ORL_BASE | {6'h00, pp}) && port12) begin
            if (pp == 2'h1) P1_O <= P1_O | imm; // see RULE6
            else P2_O <= P2_O | imm;
         end else if (op == OP_PORT_OUTPUT_LATCH_BUS) begin
            BUS_O <= ACC_I; // see RULE8
            BUS_OE_O <= 1'b1;
         end else if (op == OP_ANL_BASE) begin
            BUS_O <= BUS_O & imm; // see RULE9
            BUS_OE_O <= 1'b1;
         end else if (op == OP_ORL_BASE) begin
            BUS_O <= BUS_O | imm; // see RULE9
            BUS_OE_O <= 1'b1;
         end else if (op == OP_IN_BASE) begin
            BUS_OE_O <= 1'b0;
         end
      end else if (OP_VALID_I && OP_BYTE0_I == OP_IN_BASE) begin
         BUS_OE_O <= 1'b0; // see RULE7
      end
   end

   // Expander write: port number 4..7 given by low opcode bits
   always_comb begin
      EXP_WE_O = 1'b0;
      EXP_DATA_O = 4'h0;
      EXP_PORT_O = pp;
      if (exec) begin
         if (op == (OP_EXOUT_BASE | {6'h00, pp})) begin
            EXP_WE_O = 1'b1; // see RULE11
            EXP_DATA_O = ACC_I[3:0];
         end else if (op == (OP_EXAND_BASE | {6'h00, pp})) begin
            EXP_WE_O = 1'b1; // see RULE12
            EXP_DATA_O = EXP_I & ACC_I[3:0];
         end else if (op == (OP_EXOR_BASE | {6'h00, pp})) begin
            EXP_WE_O = 1'b1; // see RULE12
            EXP_DATA_O = EXP_I | ACC_I[3:0];
         end
      end
   end

   // Clock output on test pin zero
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         CLOCK_OUT_ENABLE_O <= 1'b0;
         clk_div <= 1'b0;
      end else begin
         clk_div <= ~clk_div;
         if (exec && op == OP_CLK_OUT) CLOCK_OUT_ENABLE_O <= 1'b1; // see RULE14
      end
   end
   assign TEST_PIN_ZERO_O = CLOCK_OUT_ENABLE_O & clk_div;

   // Test pin one synchroniser
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         t1_meta <= 1'b0;
         t1_s <= 1'b0;
         t1_prev <= 1'b0;
      end else begin
         t1_meta <= TEST_PIN_ONE_I;
         t1_s <= t1_meta;
         t1_prev <= t1_s;
      end
   end
   wire logic t1_fall = t1_prev & ~t1_s;

   // Timer/event counter
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cnt_mode <= STOPPED;
         TIMER_O <= 8'h00;
         prescale <= 16'h0000;
         TIMER_OVERFLOW_FLAG_O <= 1'b0;
      end else begin
         if (exec && op == OP_START_TIMER_MODE) begin
            cnt_mode <= TIMER_MODE; // see RULE17
            prescale <= 16'h0000;
         end else if (exec && op == OP_START_EVENT_COUNT) begin
            cnt_mode <= EVENT_MODE; // see RULE18
         end else if (exec && op == OP_STOP) begin
            cnt_mode <= STOPPED; // see RULE19
         end
         if (exec && op == OP_MOV_T_A) begin
            TIMER_O <= ACC_I; // see RULE16
         end else if (cnt_mode == TIMER_MODE) begin
            if (prescale == 16'(TIMER_CYC - 1)) begin
               prescale <= 16'h0000; // see RULE17
               TIMER_O <= TIMER_O + 8'h01;
               if (TIMER_O == 8'hFF) TIMER_OVERFLOW_FLAG_O <= 1'b1;
            end else begin
               prescale <= prescale + 16'h0001;
            end
         end else if (cnt_mode == EVENT_MODE && t1_fall) begin
            TIMER_O <= TIMER_O + 8'h01; // see RULE18
            if (TIMER_O == 8'hFF) TIMER_OVERFLOW_FLAG_O <= 1'b1;
         end
      end
   end

   wire logic overflow_evt = (TIMER_O == 8'hFF) &&
      ((cnt_mode == TIMER_MODE && prescale == 16'(TIMER_CYC - 1)) || (cnt_mode == EVENT_MODE && t1_fall)) &&
      !(exec && op == OP_MOV_T_A);

   // Counter interrupt enable and pending latch; the overflow flag stays as is
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         COUNTER_IRQ_ENABLE_FLAG_O <= 1'b0;
         COUNTER_IRQ_PENDING_O <= 1'b0;
      end else begin
         if (exec && op == OP_CNT_IRQ_EN) COUNTER_IRQ_ENABLE_FLAG_O <= 1'b1; // see RULE20
         else if (exec && op == OP_CNT_IRQ_DIS) COUNTER_IRQ_ENABLE_FLAG_O <= 1'b0; // see RULE21
         if (exec && op == OP_CNT_IRQ_DIS) COUNTER_IRQ_PENDING_O <= 1'b0; // see RULE21
         else if (overflow_evt && COUNTER_IRQ_ENABLE_FLAG_O) COUNTER_IRQ_PENDING_O <= 1'b1;
      end
   end

   a_call_push_pc: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // see RULE1
      exec && is_call |=> sp == $past(sp) + 3'h1 && stack[$past(sp)].pc == $past(PC_NEXT_I))
      else $error("call push wrong");
   a_ret_pop: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // see RULE2
      exec && op == OP_RET |=> sp == $past(sp) - 3'h1 && psw_hi == $past(psw_hi))
      else $error("ret pop wrong");
   a_return_restore_status_restore: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // see RULE3
      exec && op == OP_RETURN_RESTORE_STATUS |=> psw_hi == $past(top.psw_hi) && !IRQ_BLOCKED_O)
      else $error("return_restore_status restore wrong");
   a_port_output_latch_port: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // see RULE5
      exec && op == 8'h39 |=> P1_O == $past(ACC_I))
      else $error("port one latch wrong");
   a_bus_out: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // see RULE8
      exec && op == OP_PORT_OUTPUT_LATCH_BUS |=> BUS_O == $past(ACC_I) && BUS_OE_O)
      else $error("bus latch wrong");
   a_exp_input: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // see RULE10
      exec && op[7:2] == 6'h03 |-> ACC_WE_O && ACC_O[7:4] == 4'h0)
      else $error("expander input wrong");
   a_bank_sel: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // see RULE13
      exec && op == OP_SELECT_REG_BANK_ONE |=> BANK_SELECT_BIT_O)
      else $error("bank select wrong");
   a_timer_load: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // see RULE16
      exec && op == OP_MOV_T_A |-> !ACC_WE_O ##1 TIMER_O == $past(ACC_I))
      else $error("timer load wrong");
   a_stop_hold: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // see RULE19
      cnt_mode == STOPPED && !(exec && op == OP_MOV_T_A) |=> TIMER_O == $past(TIMER_O))
      else $error("stopped counter moved");
   a_dis_keeps_tf: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // see RULE21
      exec && op == OP_CNT_IRQ_DIS && !overflow_evt |=> !COUNTER_IRQ_PENDING_O &&
      TIMER_OVERFLOW_FLAG_O == $past(TIMER_OVERFLOW_FLAG_O))
      else $error("irq disable wrong");

endmodule
`default_nettype wire

// >>> design/mcu8_decode_pkg.sv
package mcu8_decode_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int TIMER_PERIOD_NS = 80000;
   localparam int TIMER_PERIOD_CYC = TIMER_PERIOD_NS / CLK_PERIOD_NS;
   localparam int EVENT_PERIOD_NS = 7500;
   localparam int EVENT_PERIOD_CYC = (EVENT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STACK_DEPTH = 8;
   localparam logic [7:0] OP_CALL_LOW = 8'h14;
   localparam logic [4:0] OP_CALL_MASK = 5'h1F;
   localparam logic [7:0] OP_RET = 8'h83;
   localparam logic [7:0] OP_RETURN_RESTORE_STATUS = 8'h93;
   localparam logic [7:0] OP_IN_BASE = 8'h08;
   localparam logic [7:0] OP_PORT_OUTPUT_LATCH_BASE = 8'h38;
   localparam logic [7:0] OP_ANL_BASE = 8'h98;
   localparam logic [7:0] OP_ORL_BASE = 8'h88;
   localparam logic [7:0] OP_PORT_OUTPUT_LATCH_BUS = 8'h02;
   localparam logic [7:0] OP_EXIN_BASE = 8'h0C;
   localparam logic [7:0] OP_EXOUT_BASE = 8'h3C;
   localparam logic [7:0] OP_EXAND_BASE = 8'h9C;
   localparam logic [7:0] OP_EXOR_BASE = 8'h8C;
   localparam logic [7:0] OP_SEL_RB0 = 8'hC5;
   localparam logic [7:0] OP_SELECT_REG_BANK_ONE = 8'hD5;
   localparam logic [7:0] OP_CLK_OUT = 8'h75;
   localparam logic [7:0] OP_MOV_A_T = 8'h42;
   localparam logic [7:0] OP_MOV_T_A = 8'h62;
   localparam logic [7:0] OP_START_TIMER_MODE = 8'h55;
   localparam logic [7:0] OP_START_EVENT_COUNT = 8'h45;
   localparam logic [7:0] OP_STOP = 8'h65;
   localparam logic [7:0] OP_CNT_IRQ_EN = 8'h25;
   localparam logic [7:0] OP_CNT_IRQ_DIS = 8'h35;
   localparam logic [7:0] OP_ADD_BASE = 8'h60;
   localparam logic [7:0] OP_ADDC_BASE = 8'h70;
   localparam logic [7:0] OP_ADD_IMM = 8'h03;
   localparam logic [7:0] OP_ADDC_IMM = 8'h13;
   localparam logic [7:0] OP_DA = 8'h57;
   localparam logic [7:0] RESET_BYTE = 8'hFF;
   localparam logic [3:0] RESET_NIB = 4'hF;
   typedef struct packed {
      logic [11:0] pc;
      logic [3:0] psw_hi;
   } stack_entry_s;
   typedef struct packed {
      logic carry;
      logic aux_carry;
      logic [7:0] value;
   } alu_result_s;
endpackage

// >>> verification/mcu8_port_partner.sv
`timescale 1ns/10ps
`default_nettype none
module mcu8_port_partner
   import mcu8_decode_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] p1_latch_i,
   input wire logic [7:0] p2_latch_i,
   input wire logic [7:0] bus_drv_i,
   input wire logic bus_oe_i,
   input wire logic [1:0] exp_port_i,
   input wire logic [3:0] exp_data_i,
   input wire logic exp_we_i,
   input wire logic ev_run_i,
   output logic [7:0] p1_pins_o,
   output logic [7:0] p2_pins_o,
   output logic [7:0] bus_pins_o,
   output logic [3:0] exp_rd_o,
   output logic t1_o
);
   logic [3:0] nib [4];
   int cnt;
   // Quasi-bidirectional pins: outside loads hold some bits low
   assign p1_pins_o = p1_latch_i & 8'hE7;
   assign p2_pins_o = p2_latch_i & 8'h7E;
   // A peripheral drives the bus whenever the block lets go of it
   assign bus_pins_o = bus_oe_i ? bus_drv_i : 8'hC3;
   assign exp_rd_o = nib[exp_port_i];
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         nib[0] <= 4'h9;
         nib[1] <= 4'h6;
         nib[2] <= 4'hA;
         nib[3] <= 4'h5;
      end else if (exp_we_i) begin
         nib[exp_port_i] <= exp_data_i;
      end
   end
   // Event source holds each level a full minimum period and idles high
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt <= 0;
         t1_o <= 1'b1;
      end else if (!ev_run_i) begin
         cnt <= 0;
         t1_o <= 1'b1;
      end else if (cnt == EVENT_PERIOD_CYC - 1) begin
         cnt <= 0;
         t1_o <= ~t1_o;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin \
   cmp_count++; \
   if ((a) !== (e)) begin \
      failures++; \
      $display("unexpected at %0t: got %0h expected %0h", $time, (a), (e)); \
   end \
end
module tb;
   localparam int TCYC = 4;
   logic clk = 1'b0;
   logic resetn, op_valid, carry, memory_bank_flag, ev_run, t1;
   logic [7:0] b0, b1, acc, operand, p1_i, p2_i, bus_i, p1_o, p2_o, bus_o, acc_o, program_status_word, timer, v;
   logic [11:0] pc_next, pc_o, c_pc;
   logic [3:0] exp_i, exp_d, c_xd;
   logic [2:0] sp;
   logic [1:0] exp_p, c_xp;
   logic done, acc_we, pc_we, bus_oe, exp_we, bank, clk_en, t0, tovf, irq_en, irq_pend, irq_blk;
   logic c_acc_we, c_pc_we, c_xwe, last;
   logic [7:0] c_acc;
   logic [36:0] rows [28];
   logic [36:0] r;
   int failures = 0, cmp_count = 0, cyc = 0, n = 0, ev_n = 0;

   mcu8_call_io_timer_decode #(.TIMER_CYC(TCYC)) DUT (.CLK_I(clk), .RESETN_I(resetn), .OP_VALID_I(op_valid),
      .OP_BYTE0_I(b0), .OP_BYTE1_I(b1), .ACC_I(acc), .PC_NEXT_I(pc_next), .CARRY_I(carry),
      .OPERAND_I(operand), .P1_I(p1_i), .P2_I(p2_i), .BUS_I(bus_i), .EXP_I(exp_i),
      .TEST_PIN_ONE_I(t1), .MEMORY_BANK_FLAG_I(memory_bank_flag), .OP_DONE_O(done), .ACC_WE_O(acc_we),
      .ACC_O(acc_o), .PC_WE_O(pc_we), .PC_O(pc_o), .PROGRAM_STATUS_WORD_O(program_status_word), .STACK_POINTER_O(sp),
      .P1_O(p1_o), .P2_O(p2_o), .BUS_O(bus_o), .BUS_OE_O(bus_oe), .EXP_PORT_O(exp_p),
      .EXP_DATA_O(exp_d), .EXP_WE_O(exp_we), .BANK_SELECT_BIT_O(bank), .CLOCK_OUT_ENABLE_O(clk_en),
      .TEST_PIN_ZERO_O(t0), .TIMER_O(timer), .TIMER_OVERFLOW_FLAG_O(tovf),
      .COUNTER_IRQ_ENABLE_FLAG_O(irq_en), .COUNTER_IRQ_PENDING_O(irq_pend), .IRQ_BLOCKED_O(irq_blk));

   mcu8_port_partner far_side (.clk_i(clk), .resetn_i(resetn), .p1_latch_i(p1_o), .p2_latch_i(p2_o),
      .bus_drv_i(bus_o), .bus_oe_i(bus_oe), .exp_port_i(exp_p), .exp_data_i(exp_d), .exp_we_i(exp_we),
      .ev_run_i(ev_run), .p1_pins_o(p1_i), .p2_pins_o(p2_i), .bus_pins_o(bus_i), .exp_rd_o(exp_i),
      .t1_o(t1));

   always #12.5 clk = ~clk;
   always @(negedge t1) ev_n++;

   task automatic report_and_stop;
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         failures++;
         report_and_stop();
      end
   end

   // Issue one instruction, capture the execute-cycle outputs, return once registers settle
   task automatic op(input logic [7:0] x0, input logic [7:0] x1, input logic [7:0] a);
      @(posedge clk);
      b0 <= x0;
      b1 <= x1;
      acc <= a;
      op_valid <= 1'b1;
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      `CHK(done, 1'b1)
      c_acc_we = acc_we;
      c_acc = acc_o;
      c_pc_we = pc_we;
      c_pc = pc_o;
      c_xwe = exp_we;
      c_xp = exp_p;
      c_xd = exp_d;
      @(posedge clk);
      #1;
   endtask

   initial begin
      resetn = 1'b0;
      op_valid = 1'b0;
      b0 = 8'h00;
      b1 = 8'h00;
      acc = 8'h00;
      operand = 8'h29;
      carry = 1'b1;
      memory_bank_flag = 1'b1;
      ev_run = 1'b0;
      pc_next = 12'h000;
      // b0, b1, acc, check select, expected
      rows = '{{8'h09, 8'h00, 8'h00, 3'h0, 10'h0E7}, {8'h0A, 8'h00, 8'h00, 3'h0, 10'h07E},
         {8'h39, 8'h00, 8'hA5, 3'h1, 10'h0A5}, {8'h99, 8'h0F, 8'h00, 3'h1, 10'h005},
         {8'h89, 8'hC0, 8'h00, 3'h1, 10'h0C5}, {8'h09, 8'h00, 8'h00, 3'h0, 10'h0C5},
         {8'h3A, 8'h00, 8'h5A, 3'h2, 10'h05A}, {8'h9A, 8'hF0, 8'h00, 3'h2, 10'h050},
         {8'h8A, 8'h0A, 8'h00, 3'h2, 10'h05A}, {8'h02, 8'h00, 8'h96, 3'h3, 10'h096},
         {8'h98, 8'hF0, 8'h00, 3'h3, 10'h090}, {8'h88, 8'h03, 8'h00, 3'h3, 10'h093},
         {8'h08, 8'h00, 8'h00, 3'h0, 10'h0C3}, {8'h0C, 8'h00, 8'hFF, 3'h0, 10'h009},
         {8'h0D, 8'h00, 8'h00, 3'h0, 10'h006}, {8'h3E, 8'h00, 8'hF3, 3'h4, 10'h003},
         {8'h9F, 8'h00, 8'h0C, 3'h4, 10'h004}, {8'h8C, 8'h00, 8'h06, 3'h4, 10'h00F},
         {8'h0E, 8'h00, 8'h00, 3'h0, 10'h003}, {8'hD5, 8'h00, 8'h00, 3'h5, 10'h001},
         {8'hC5, 8'h00, 8'h00, 3'h5, 10'h000}, {8'h62, 8'h00, 8'h7B, 3'h6, 10'h07B},
         {8'h42, 8'h00, 8'h00, 3'h0, 10'h07B}, {8'h6D, 8'h00, 8'h18, 3'h7, 10'h141},
         {8'h79, 8'h00, 8'hF0, 3'h7, 10'h21A}, {8'h03, 8'h6B, 8'h9C, 3'h7, 10'h307},
         {8'h13, 8'h00, 8'hFF, 3'h7, 10'h300}, {8'h03, 8'h01, 8'h12, 3'h7, 10'h013}};
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      #1;
      `CHK({p1_o, p2_o, bus_oe, sp, timer, clk_en}, {8'hFF, 8'hFF, 1'b0, 3'h0, 8'h00, 1'b0})
      for (int i = 0; i < 28; i++) begin
         r = rows[i];
         op(r[36:29], r[28:21], r[20:13]);
         case (r[12:10])
            3'h0: `CHK({c_acc_we, c_acc}, {1'b1, r[7:0]})
            3'h1: `CHK(p1_o, r[7:0])
            3'h2: `CHK(p2_o, r[7:0])
            3'h3: `CHK({bus_oe, bus_o}, {1'b1, r[7:0]})
            3'h4: `CHK({c_acc_we, c_xwe, c_xp, c_xd}, {2'b01, r[30:29], r[3:0]})
            3'h5: `CHK({bank, program_status_word[4]}, {2{r[0]}})
            3'h6: `CHK({c_acc_we, timer}, {1'b0, r[7:0]})
            default: `CHK({program_status_word[7:6], c_acc}, r[9:0])
         endcase
      end
      op(8'h57, 8'h00, 8'h9A);
      `CHK({program_status_word[7:6], c_acc_we, c_acc}, 11'h700)
      // Call with carry, aux carry and bank one set, then clear them all before returning
      op(8'h03, 8'h6B, 8'h9C);
      op(8'hD5, 8'h00, 8'h00);
      pc_next <= 12'h123;
      op(8'hB4, 8'hA3, 8'h00);
      `CHK({c_pc_we, c_pc, sp, irq_blk}, {1'b1, 12'hDA3, 3'h1, 1'b1})
      op(8'h03, 8'h01, 8'h12);
      op(8'hC5, 8'h00, 8'h00);
      op(8'h93, 8'h00, 8'h00);
      `CHK({c_pc_we, c_pc, program_status_word[7:4], sp, irq_blk}, {1'b1, 12'h123, 4'hD, 3'h0, 1'b0})
      pc_next <= 12'h456;
      op(8'hB4, 8'hA3, 8'h00);
      op(8'h03, 8'h01, 8'h12);
      op(8'hC5, 8'h00, 8'h00);
      op(8'h83, 8'h00, 8'h00);
      `CHK({c_pc, program_status_word[7:4], sp, irq_blk}, {12'h456, 4'h0, 3'h0, 1'b1})
      for (int i = 0; i < 9; i++) begin
         pc_next <= 12'(i);
         op(8'h14, 8'h00, 8'h00);
         `CHK(sp, 3'(i + 1))
      end
      op(8'h83, 8'h00, 8'h00);
      `CHK({c_pc, sp}, {12'h008, 3'h0})
      // Timer mode from one below wrap, overflow with the counter interrupt enabled
      op(8'h62, 8'h00, 8'hFE);
      op(8'h25, 8'h00, 8'h00);
      `CHK(irq_en, 1'b1)
      op(8'h55, 8'h00, 8'h00);
      n = 0;
      while (timer !== 8'hFF && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      n = 0;
      while (timer !== 8'h00 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK(n, TCYC)
      `CHK({tovf, irq_pend}, 2'b11)
      op(8'h65, 8'h00, 8'h00);
      v = timer;
      repeat (3 * TCYC) @(posedge clk);
      #1;
      `CHK(timer, v)
      op(8'h35, 8'h00, 8'h00);
      `CHK({irq_en, irq_pend, tovf}, 3'b001)
      // Event mode counts falling edges on the test input, then stops
      op(8'h62, 8'h00, 8'h10);
      op(8'h45, 8'h00, 8'h00);
      ev_n = 0;
      ev_run <= 1'b1;
      repeat (1900) @(posedge clk);
      ev_run <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      `CHK(timer, 8'h10 + 8'(ev_n))
      op(8'h65, 8'h00, 8'h00);
      v = timer;
      ev_run <= 1'b1;
      repeat (700) @(posedge clk);
      ev_run <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      `CHK(timer, v)
      `CHK({clk_en, t0}, 2'b00)
      op(8'h75, 8'h00, 8'h00);
      n = 0;
      last = t0;
      repeat (8) begin
         @(posedge clk);
         #1;
         if (t0 !== last) n++;
         last = t0;
      end
      `CHK({clk_en, n > 3}, 2'b11)
      report_and_stop();
   end
endmodule
`default_nettype wire
